// ### logic/fpe_pkg.sv
package fpe_pkg;
  localparam int unsigned CLK_MHZ = 100;
  // Wait times in microseconds (the two totals in milliseconds), as printed.
  localparam int unsigned T_SWE_US = 10;
  localparam int unsigned T_PSU_US = 50;
  localparam int unsigned T_PPULSE_MIN_US = 150;
  localparam int unsigned T_PPULSE_MAX_US = 500;
  localparam int unsigned T_PCLR_US = 10;
  localparam int unsigned T_PV_SET_US = 4;
  localparam int unsigned T_DUMMY_US = 2;
  localparam int unsigned T_PV_CLR_US = 4;
  localparam int unsigned T_ESU_US = 200;
  localparam int unsigned T_EPULSE_MIN_US = 5000;
  localparam int unsigned T_EPULSE_MAX_US = 10000;
  localparam int unsigned T_ECLR_US = 10;
  localparam int unsigned T_EV_SET_US = 20;
  localparam int unsigned T_EV_CLR_US = 5;
  localparam int unsigned T_PROG_TOTAL_MS = 200;
  localparam int unsigned T_ERASE_TOTAL_MS = 1200;
  localparam int unsigned PROG_PASS_MAX = 403;
  localparam int unsigned ERASE_PASS_MAX = 120;
  localparam int unsigned PROG_SHORT_PASSES = 4;
  localparam int unsigned PROG_UNIT_BYTES = 32;
  // Cycles that the timer handshake adds to every loaded wait.
  localparam int unsigned C_STEP_LAG = 2;
  // Cycle counts: minimums round up (integer us times whole MHz are exact).
  localparam int unsigned C_SWE = T_SWE_US * CLK_MHZ;
  localparam int unsigned C_PSU = T_PSU_US * CLK_MHZ;
  localparam int unsigned C_PPULSE_MIN = T_PPULSE_MIN_US * CLK_MHZ;
  localparam int unsigned C_PPULSE_MAX = T_PPULSE_MAX_US * CLK_MHZ;
  localparam int unsigned C_PCLR = T_PCLR_US * CLK_MHZ;
  localparam int unsigned C_PV_SET = T_PV_SET_US * CLK_MHZ;
  localparam int unsigned C_DUMMY = T_DUMMY_US * CLK_MHZ;
  localparam int unsigned C_PV_CLR = T_PV_CLR_US * CLK_MHZ;
  localparam int unsigned C_ESU = T_ESU_US * CLK_MHZ;
  localparam int unsigned C_EPULSE_MIN = T_EPULSE_MIN_US * CLK_MHZ;
  localparam int unsigned C_EPULSE_MAX = T_EPULSE_MAX_US * CLK_MHZ;
  localparam int unsigned C_ECLR = T_ECLR_US * CLK_MHZ;
  localparam int unsigned C_EV_SET = T_EV_SET_US * CLK_MHZ;
  localparam int unsigned C_EV_CLR = T_EV_CLR_US * CLK_MHZ;
  localparam int unsigned C_PROG_TOTAL = T_PROG_TOTAL_MS * 1000 * CLK_MHZ;
  localparam int unsigned C_ERASE_TOTAL = T_ERASE_TOTAL_MS * 1000 * CLK_MHZ;
  // APB register offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_PPULSE = 8'h08;
  localparam logic [7:0] REG_EPULSE = 8'h0c;
  localparam logic [7:0] REG_PLIMIT = 8'h10;
  localparam logic [7:0] REG_ELIMIT = 8'h14;
  localparam logic [7:0] REG_PASSES = 8'h18;
  localparam logic [7:0] REG_MUXDATA = 8'h1c;
  // Control and status fields.
  localparam int unsigned CTRL_START_PROG = 0;
  localparam int unsigned CTRL_START_ERASE = 1;
  localparam int unsigned CTRL_ABORT = 2;
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_DONE = 1;
  localparam int unsigned ST_FAIL = 2;
  localparam int unsigned ST_OVERTIME = 3;
  // Reset values of the pulse-width registers (microseconds) and of the pass-limit registers.
  localparam logic [31:0] RST_PPULSE = 32'h0000_01f4;
  localparam logic [31:0] RST_EPULSE = 32'h0000_2710;
  localparam logic [31:0] RST_PLIMIT = 32'h0000_0193;
  localparam logic [31:0] RST_ELIMIT = 32'h0000_0078;
  typedef enum logic [4:0] {
    FPE_IDLE, FPE_SWE, FPE_SETUP, FPE_PULSE, FPE_PCLR, FPE_SCLR,
    FPE_VSET, FPE_DUMMY, FPE_DWAIT, FPE_READ, FPE_VCLR, FPE_DONE
  } fpe_state_t;
endpackage : fpe_pkg

// ### logic/fpe_sequencer.sv
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ns
module fpe_sequencer (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic software_write_enable,
  output logic program_setup_bit,
  output logic program_pulse_bit,
  output logic program_verify_bit,
  output logic erase_setup_bit,
  output logic erase_pulse_bit,
  output logic erase_verify_bit,
  output logic dummy_write,
  output logic verify_read,
  input wire logic verify_ok
);
  localparam int unsigned TW = 28;
  fpe_pkg::fpe_state_t state;
  logic erase_mode;
  logic [31:0] ppulse_us;
  logic [31:0] epulse_us;
  logic [31:0] plimit;
  logic [31:0] elimit;
  logic [15:0] passes;
  logic [31:0] pulse_sum;
  logic busy, done_flag, fail_flag, overtime;
  logic [7:0] verify_data;
  logic tload;
  logic [TW-1:0] tcount;
  logic tdone;
  logic wr_acc, rd_acc;
  logic start_p, start_e, abort;
  logic [31:0] pulse_cyc;
  logic [31:0] sum_limit;
  logic [31:0] pass_limit;

  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign start_p = wr_acc && paddr == fpe_pkg::REG_CTRL && pwdata[fpe_pkg::CTRL_START_PROG];
  assign start_e = wr_acc && paddr == fpe_pkg::REG_CTRL && pwdata[fpe_pkg::CTRL_START_ERASE];
  assign abort = wr_acc && paddr == fpe_pkg::REG_CTRL && pwdata[fpe_pkg::CTRL_ABORT];

  always_comb begin
    if (erase_mode) begin
      pulse_cyc = epulse_us * fpe_pkg::CLK_MHZ;
    end else if (passes < 16'(fpe_pkg::PROG_SHORT_PASSES)) begin
      pulse_cyc = fpe_pkg::C_PPULSE_MIN;
    end else begin
      pulse_cyc = ppulse_us * fpe_pkg::CLK_MHZ;
    end
  end
  assign sum_limit = erase_mode ? fpe_pkg::C_ERASE_TOTAL : fpe_pkg::C_PROG_TOTAL;
  assign pass_limit = erase_mode ? elimit : plimit;

  fpe_timer #(.W(TW)) u_timer (
    .clk(clk),
    .rstn(rstn),
    .load(tload),
    .count(tcount),
    .done(tdone)
  );

  // APB slave: single-cycle access phase, unmapped reads as zero, pslverr only for addresses above REG_MUXDATA.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && paddr > fpe_pkg::REG_MUXDATA;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          fpe_pkg::REG_STATUS: prdata <= {28'h0000000, overtime, fail_flag, done_flag, busy};
          fpe_pkg::REG_PPULSE: prdata <= ppulse_us;
          fpe_pkg::REG_EPULSE: prdata <= epulse_us;
          fpe_pkg::REG_PLIMIT: prdata <= plimit;
          fpe_pkg::REG_ELIMIT: prdata <= elimit;
          fpe_pkg::REG_PASSES: prdata <= {16'h0000, passes};
          fpe_pkg::REG_MUXDATA: prdata <= {24'h000000, verify_data};
          default: prdata <= '0;
        endcase
      end
    end
  end

  // Settings clamp to the legal window, so software cannot break pulse timing.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ppulse_us <= fpe_pkg::RST_PPULSE;
      epulse_us <= fpe_pkg::RST_EPULSE;
      plimit <= fpe_pkg::RST_PLIMIT;
      elimit <= fpe_pkg::RST_ELIMIT;
    end else if (wr_acc && !busy) begin
      if (paddr == fpe_pkg::REG_PPULSE) begin
        ppulse_us <= pwdata < fpe_pkg::T_PPULSE_MIN_US ? fpe_pkg::T_PPULSE_MIN_US :
                     pwdata > fpe_pkg::T_PPULSE_MAX_US ? fpe_pkg::T_PPULSE_MAX_US : pwdata;
      end
      if (paddr == fpe_pkg::REG_EPULSE) begin
        epulse_us <= pwdata < fpe_pkg::T_EPULSE_MIN_US ? fpe_pkg::T_EPULSE_MIN_US :
                     pwdata > fpe_pkg::T_EPULSE_MAX_US ? fpe_pkg::T_EPULSE_MAX_US : pwdata;
      end
      if (paddr == fpe_pkg::REG_PLIMIT) begin
        plimit <= pwdata > fpe_pkg::PROG_PASS_MAX ? fpe_pkg::PROG_PASS_MAX : pwdata;
      end
      if (paddr == fpe_pkg::REG_ELIMIT) begin
        elimit <= pwdata > fpe_pkg::ERASE_PASS_MAX ? fpe_pkg::ERASE_PASS_MAX : pwdata;
      end
    end
  end

  // Main sequence; every wait is a timer load followed by tdone.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= fpe_pkg::FPE_IDLE;
      erase_mode <= 1'b0;
      busy <= 1'b0;
      done_flag <= 1'b0;
      fail_flag <= 1'b0;
      overtime <= 1'b0;
      passes <= '0;
      pulse_sum <= '0;
      tload <= 1'b0;
      tcount <= '0;
      software_write_enable <= 1'b0;
      program_setup_bit <= 1'b0;
      program_pulse_bit <= 1'b0;
      program_verify_bit <= 1'b0;
      erase_setup_bit <= 1'b0;
      erase_pulse_bit <= 1'b0;
      erase_verify_bit <= 1'b0;
      dummy_write <= 1'b0;
      verify_read <= 1'b0;
      verify_data <= '0;
    end else begin
      tload <= 1'b0;
      dummy_write <= 1'b0;
      verify_read <= 1'b0;
      if (abort && busy) begin
        state <= fpe_pkg::FPE_DONE;
        fail_flag <= 1'b1;
        program_setup_bit <= 1'b0;
        program_pulse_bit <= 1'b0;
        program_verify_bit <= 1'b0;
        erase_setup_bit <= 1'b0;
        erase_pulse_bit <= 1'b0;
        erase_verify_bit <= 1'b0;
      end else begin
        unique case (state)
          fpe_pkg::FPE_IDLE: begin
            if (start_p || start_e) begin
              erase_mode <= start_e && !start_p;
              busy <= 1'b1;
              done_flag <= 1'b0;
              fail_flag <= 1'b0;
              overtime <= 1'b0;
              passes <= '0;
              pulse_sum <= '0;
              software_write_enable <= 1'b1;
              tload <= 1'b1;
              tcount <= TW'(fpe_pkg::C_SWE);
              state <= fpe_pkg::FPE_SWE;
            end
          end
          fpe_pkg::FPE_SWE: begin
            if (tdone) begin
              program_setup_bit <= !erase_mode;
              erase_setup_bit <= erase_mode;
              tload <= 1'b1;
              tcount <= erase_mode ? TW'(fpe_pkg::C_ESU) : TW'(fpe_pkg::C_PSU);
              state <= fpe_pkg::FPE_SETUP;
            end
          end
          fpe_pkg::FPE_SETUP: begin
            if (tdone) begin
              program_pulse_bit <= !erase_mode;
              erase_pulse_bit <= erase_mode;
              tload <= 1'b1;
              // pulse from counter
              // The handshake lag is taken off here, so a pulse at the maximum stays legal.
              tcount <= TW'(pulse_cyc - fpe_pkg::C_STEP_LAG);
              pulse_sum <= pulse_sum + pulse_cyc;
              passes <= passes + 16'h0001;
              state <= fpe_pkg::FPE_PULSE;
            end
          end
          fpe_pkg::FPE_PULSE: begin
            if (tdone) begin
              program_pulse_bit <= 1'b0;
              erase_pulse_bit <= 1'b0;
              tload <= 1'b1;
              tcount <= erase_mode ? TW'(fpe_pkg::C_ECLR) : TW'(fpe_pkg::C_PCLR);
              state <= fpe_pkg::FPE_PCLR;
            end
          end
          fpe_pkg::FPE_PCLR: begin
            if (tdone) begin
              program_setup_bit <= 1'b0;
              erase_setup_bit <= 1'b0;
              tload <= 1'b1;
              tcount <= erase_mode ? TW'(fpe_pkg::C_ECLR) : TW'(fpe_pkg::C_PCLR);
              state <= fpe_pkg::FPE_SCLR;
            end
          end
          fpe_pkg::FPE_SCLR: begin
            if (tdone) begin
              program_verify_bit <= !erase_mode;
              erase_verify_bit <= erase_mode;
              tload <= 1'b1;
              tcount <= erase_mode ? TW'(fpe_pkg::C_EV_SET) : TW'(fpe_pkg::C_PV_SET);
              state <= fpe_pkg::FPE_VSET;
            end
          end
          fpe_pkg::FPE_VSET: begin
            if (tdone) begin
              dummy_write <= 1'b1;
              state <= fpe_pkg::FPE_DUMMY;
            end
          end
          fpe_pkg::FPE_DUMMY: begin
            tload <= 1'b1;
            tcount <= TW'(fpe_pkg::C_DUMMY);
            state <= fpe_pkg::FPE_DWAIT;
          end
          fpe_pkg::FPE_DWAIT: begin
            if (tdone) begin
              verify_read <= 1'b1;
              state <= fpe_pkg::FPE_READ;
            end
          end
          fpe_pkg::FPE_READ: begin
            verify_data <= {7'h00, verify_ok};
            done_flag <= verify_ok;
            program_verify_bit <= 1'b0;
            erase_verify_bit <= 1'b0;
            tload <= 1'b1;
            tcount <= erase_mode ? TW'(fpe_pkg::C_EV_CLR) : TW'(fpe_pkg::C_PV_CLR);
            state <= fpe_pkg::FPE_VCLR;
          end
          fpe_pkg::FPE_VCLR: begin
            if (tdone) begin
              if (done_flag) begin
                state <= fpe_pkg::FPE_DONE;
              end else if (32'(passes) >= pass_limit) begin
                fail_flag <= 1'b1;
                state <= fpe_pkg::FPE_DONE;
              end else if (pulse_sum + pulse_cyc > sum_limit) begin
                fail_flag <= 1'b1;
                overtime <= 1'b1;
                state <= fpe_pkg::FPE_DONE;
              end else begin
                program_setup_bit <= !erase_mode;
                erase_setup_bit <= erase_mode;
                tload <= 1'b1;
                tcount <= erase_mode ? TW'(fpe_pkg::C_ESU) : TW'(fpe_pkg::C_PSU);
                state <= fpe_pkg::FPE_SETUP;
              end
            end
          end
          fpe_pkg::FPE_DONE: begin
            software_write_enable <= 1'b0;
            busy <= 1'b0;
            state <= fpe_pkg::FPE_IDLE;
          end
          default: state <= fpe_pkg::FPE_IDLE;
        endcase
      end
    end
  end
endmodule : fpe_sequencer

// ### logic/fpe_timer.sv
`timescale 1ns/1ns
// Down counter; done pulses for one cycle as the loaded count reaches zero.
module fpe_timer #(
  parameter int unsigned W = 28
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic load,
  input wire logic [W-1:0] count,
  output logic done
);
  logic [W-1:0] remain;
  logic running;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      remain <= '0;
      running <= 1'b0;
      done <= 1'b0;
    end else if (load) begin
      remain <= count;
      running <= 1'b1;
      done <= 1'b0;
    end else if (running) begin
      remain <= remain - W'(1);
      done <= (remain <= W'(1));
      running <= (remain > W'(1));
    end else begin
      done <= 1'b0;
    end
  end
endmodule : fpe_timer

// ### verif/fpe_chk.sv
`timescale 1ns/1ns
module fpe_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire logic software_write_enable,
  input wire logic program_setup_bit,
  input wire logic program_pulse_bit,
  input wire logic program_verify_bit,
  input wire logic erase_setup_bit,
  input wire logic erase_pulse_bit,
  input wire logic erase_verify_bit,
  input wire logic dummy_write,
  input wire logic verify_read
);
  logic [6:0] bits;
  logic [6:0] prev;
  logic [20:0] since;
  logic [8:0] npass;
  logic [26:0] ontime;
  logic [1:0] vclr;
  logic evt;
  assign bits = {software_write_enable, program_setup_bit, program_pulse_bit,
    program_verify_bit, erase_setup_bit, erase_pulse_bit, erase_verify_bit};
  assign evt = (bits != prev) || dummy_write || verify_read;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // whole cycle count
  // Every wait is measured from the last change at the flash pins.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prev <= '0;
      since <= '0;
    end else begin
      prev <= bits;
      since <= evt ? '0 : since + 21'h1;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      npass <= '0;
    end else if (bits[6] && !prev[6]) begin
      npass <= '0;
    end else if ((bits[4] && !prev[4]) || (bits[1] && !prev[1])) begin
      npass <= npass + 9'h1;
    end
  end
  // Summed pulse time of one operation.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ontime <= '0;
    end else if (bits[6] && !prev[6]) begin
      ontime <= '0;
    end else if (bits[4] || bits[1]) begin
      ontime <= ontime + 27'h1;
    end
  end
  // Remembers that the last change cleared a verify bit.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vclr <= '0;
    end else if (evt) begin
      vclr <= {prev[3] && !bits[3], prev[0] && !bits[0]};
    end
  end
  psu_wait_a: assert property (
    $rose(program_pulse_bit) |-> program_setup_bit && since >= fpe_pkg::C_PSU - 1
  ) else $error("program pulse too soon after setup");
  ppulse_width_a: assert property (
    $fell(program_pulse_bit) && program_setup_bit |->
      since >= fpe_pkg::C_PPULSE_MIN - 1 && since < fpe_pkg::C_PPULSE_MAX
  ) else $error("program pulse width out of range");
  // Abort drops pulse and setup together on purpose, so only a lone setup clear is timed.
  pclr_wait_a: assert property (
    ($fell(program_setup_bit) && !$fell(program_pulse_bit)) || $rose(program_verify_bit) |->
      since >= fpe_pkg::C_PCLR - 1
  ) else $error("short wait after program clear");
  dummy_wait_a: assert property (
    $rose(dummy_write) |->
      since >= (program_verify_bit ? fpe_pkg::C_PV_SET : fpe_pkg::C_EV_SET) - 1
  ) else $error("dummy write too soon after verify set");
  read_wait_a: assert property (
    $rose(verify_read) |-> since >= fpe_pkg::C_DUMMY - 1
  ) else $error("read back too soon after dummy write");
  vclr_wait_a: assert property (
    evt && (vclr != 2'b00) |->
      since >= (vclr[1] ? fpe_pkg::C_PV_CLR : fpe_pkg::C_EV_CLR) - 1
  ) else $error("short wait after verify clear");
  short_pulse_a: assert property (
    $fell(program_pulse_bit) && program_setup_bit && npass <= 9'h4 |->
      since <= fpe_pkg::C_PPULSE_MIN + 2
  ) else $error("early pass pulse not minimum");
  pass_cap_a: assert property (
    $rose(program_pulse_bit) |-> npass < fpe_pkg::PROG_PASS_MAX
  ) else $error("program pass count over limit");
  esu_wait_a: assert property (
    $rose(erase_pulse_bit) |-> erase_setup_bit && since >= fpe_pkg::C_ESU - 1
  ) else $error("erase pulse too soon after setup");
  epulse_width_a: assert property (
    $fell(erase_pulse_bit) && erase_setup_bit |->
      since >= fpe_pkg::C_EPULSE_MIN - 1 && since < fpe_pkg::C_EPULSE_MAX
  ) else $error("erase pulse width out of range");
  eclr_wait_a: assert property (
    ($fell(erase_setup_bit) && !$fell(erase_pulse_bit)) || $rose(erase_verify_bit) |->
      since >= fpe_pkg::C_ECLR - 1
  ) else $error("short wait after erase clear");
  bits_released_a: assert property (
    !software_write_enable |-> bits[5:0] == 6'h00
  ) else $error("control bit left set without write enable");
  epass_cap_a: assert property (
    $rose(erase_pulse_bit) |-> npass < fpe_pkg::ERASE_PASS_MAX
  ) else $error("erase pass count over limit");
  prog_budget_a: assert property (
    program_pulse_bit |-> ontime < fpe_pkg::C_PROG_TOTAL
  ) else $error("program pulse time over budget");
  erase_budget_a: assert property (
    erase_pulse_bit |-> ontime < fpe_pkg::C_ERASE_TOTAL
  ) else $error("erase pulse time over budget");
  pulse_max_a: assert property (
    $fell(program_pulse_bit) && program_setup_bit |-> ontime <= npass * fpe_pkg::C_PPULSE_MAX
  ) else $error("program pulse total over pass maximum");
  cover property ($fell(program_pulse_bit) && npass == 9'h2);
  cover property ($rose(erase_pulse_bit));
  cover property ($fell(software_write_enable));
endmodule : fpe_chk
bind fpe_sequencer fpe_chk chk (.clk, .rstn, .software_write_enable, .program_setup_bit,
  .program_pulse_bit, .program_verify_bit, .erase_setup_bit, .erase_pulse_bit,
  .erase_verify_bit, .dummy_write, .verify_read);

// ### verif/fpe_flash_model.sv
`timescale 1ns/1ns
module fpe_flash_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic software_write_enable,
  input wire logic verify_read,
  input wire logic [7:0] ok_pass,
  output logic verify_ok
);
  logic [7:0] reads;
  logic swe_d;
  logic junk;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reads <= 8'h00;
      swe_d <= 1'b0;
    end else begin
      swe_d <= software_write_enable;
      if (software_write_enable && !swe_d) begin
        reads <= 8'h00;
      end else if (verify_read) begin
        reads <= reads + 8'h01;
      end
    end
  end
  // Outside the answer cycle the line toggles, so a late sample cannot pass by luck.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      junk <= 1'b0;
    end else begin
      junk <= ~junk;
    end
  end
  // The answer stands in the read strobe cycle, where the sequencer samples it.
  assign verify_ok = verify_read ? (ok_pass != 8'h00) && (reads + 8'h01 >= ok_pass) : junk;
endmodule : fpe_flash_model

// ### verif/tb.sv
`timescale 1ns/1ns
module tb;
  typedef struct packed {
    logic w;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] x;
    logic e;
  } fpe_row_t;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, verify_ok, dummy_write, verify_read;
  logic software_write_enable, program_setup_bit, program_pulse_bit, program_verify_bit;
  logic erase_setup_bit, erase_pulse_bit, erase_verify_bit, e;
  logic [7:0] paddr, ok_pass;
  logic [31:0] pwdata, prdata, r;
  logic [6:0] bits;
  int errors, checks, i;
  fpe_row_t rows [12] = '{
    '{1'b0, 8'h00, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h04, 32'h0, 32'h0, 1'b0},
    '{1'b0, 8'h08, 32'h0, 32'h1f4, 1'b0}, '{1'b0, 8'h0c, 32'h0, 32'h2710, 1'b0},
    '{1'b0, 8'h10, 32'h0, 32'h193, 1'b0}, '{1'b0, 8'h14, 32'h0, 32'h78, 1'b0},
    '{1'b0, 8'h18, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h20, 32'h0, 32'h0, 1'b1},
    '{1'b1, 8'h08, 32'h64, 32'h0, 1'b0}, '{1'b0, 8'h08, 32'h0, 32'h96, 1'b0},
    '{1'b1, 8'h10, 32'h1, 32'h0, 1'b0}, '{1'b0, 8'h10, 32'h0, 32'h1, 1'b0}};
  assign bits = {software_write_enable, program_setup_bit, program_pulse_bit,
    program_verify_bit, erase_setup_bit, erase_pulse_bit, erase_verify_bit};
  fpe_sequencer dut (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .software_write_enable, .program_setup_bit, .program_pulse_bit,
    .program_verify_bit, .erase_setup_bit, .erase_pulse_bit, .erase_verify_bit,
    .dummy_write, .verify_read, .verify_ok);
  fpe_flash_model flash (.clk, .rstn, .software_write_enable, .verify_read, .ok_pass,
    .verify_ok);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic end_sim;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic er);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // Read right after the edge, these are the values that edge sampled.
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  // Bounded wait on one flash pin; a level never reached counts as a mismatch.
  task automatic wait_bit(input int k, input logic v);
    int n;
    n = 0;
    while (bits[k] !== v && n < 60000) begin
      @(negedge clk);
      n++;
    end
    chk("pin level", {31'h0, v}, {31'h0, bits[k]});
    @(posedge clk);
  endtask : wait_bit
  task automatic prog(input logic [7:0] okp, input logic [31:0] st, input logic [31:0] np);
    ok_pass <= okp;
    apb(1'b1, 8'h00, 32'h1, r, e);
    wait_bit(6, 1'b1);
    apb(1'b0, 8'h04, 32'h0, r, e);
    chk("busy", 32'h1, r & 32'h1);
    wait_bit(6, 1'b0);
    apb(1'b0, 8'h04, 32'h0, r, e);
    chk("status", st, r);
    apb(1'b0, 8'h18, 32'h0, r, e);
    chk("passes", np, r);
  endtask : prog
  initial begin
    repeat (120000) @(posedge clk);
    errors++;
    end_sim();
  end
  initial begin
    {psel, penable, pwrite, rstn} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ok_pass = 8'h00;
    repeat (20) @(posedge clk);
    chk("reset pins", 32'h0, {25'h0, bits});
    rstn <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 12; i++) begin
      apb(rows[i].w, rows[i].a, rows[i].d, r, e);
      if (!rows[i].w) chk("read data", rows[i].x, r);
      chk("slave error", {31'h0, rows[i].e}, {31'h0, e});
    end
    prog(8'h00, 32'h4, 32'h1); // One pass allowed, then failure.
    apb(1'b1, 8'h10, 32'h2, r, e);
    prog(8'h02, 32'h2, 32'h2); // Second pass verifies.
    apb(1'b0, 8'h1c, 32'h0, r, e);
    chk("verify result", 32'h1, r); // Last verify passed.
    apb(1'b1, 8'h00, 32'h2, r, e);
    wait_bit(1, 1'b1); // Erase pulse reached.
    apb(1'b1, 8'h00, 32'h1, r, e);
    chk("erase pins", 32'h46, {25'h0, bits}); // Setup held and second start ignored.
    apb(1'b1, 8'h00, 32'h4, r, e);
    wait_bit(6, 1'b0); // Write enable released.
    chk("abort pins", 32'h0, {25'h0, bits}); // All bits cleared.
    apb(1'b0, 8'h04, 32'h0, r, e);
    chk("abort status", 32'h4, r); // Failure reported.
    apb(1'b1, 8'h00, 32'h1, r, e);
    wait_bit(5, 1'b1);
    rstn <= 1'b0;
    @(posedge clk);
    chk("reset pins", 32'h0, {25'h0, bits});
    rstn <= 1'b1;
    @(posedge clk);
    apb(1'b0, 8'h08, 32'h0, r, e);
    chk("pulse width reg", 32'h1f4, r);
    end_sim();
  end
endmodule : tb
